/* File: dv/pmwc_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module pmwc_assertions (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Bus
   input wire busSel,
   input wire busRd,
   input wire busWr,
   input wire [7:0] busAddr,
   input wire [31:0] busRdata,
   input wire busRvalid,
   // Events and outputs
   input wire lanWakeEvent,
   input wire energyEvent,
   input wire [1:0] powerState,
   input wire deviceReady,
   input wire wakeInterrupt,
   input wire xcvrResetN,
   input wire wakeOut,
   input wire wakeOutEn
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_img;
      busSel && busRd && busAddr == 8'h84 |=> busRvalid &&
         busRdata[13:12] == $past(powerState) &&
         busRdata[0] == $past(deviceReady);
   endproperty
   a_img: assert property (p_img) else $error("bad read image");
   property p_rv;
      busRvalid |-> $past(busSel && busRd);
   endproperty
   a_rv: assert property (p_rv) else $error("stray read answer");
   property p_lan;
      $past(powerState) == 2'h1 && powerState != 2'h1 |-> powerState == 2'h0
         && $past(lanWakeEvent || busSel && busWr && busAddr == 8'h64);
   endproperty
   a_lan: assert property (p_lan) else $error("lan hit no wake");
   property p_nrg;
      $past(powerState) == 2'h2 && powerState != 2'h2 |-> powerState == 2'h0
         && !deviceReady
         && $past(energyEvent || busSel && busWr && busAddr == 8'h64);
   endproperty
   a_nrg: assert property (p_nrg) else $error("energy no wake");
   property p_bt;
      busSel && busWr && busAddr == 8'h64 && powerState != 2'h0 |=>
         powerState == 2'h0 && !deviceReady;
   endproperty
   a_bt: assert property (p_bt) else $error("byte test no wake");
   property p_xr;
      $fell(xcvrResetN) |-> !xcvrResetN [*8];
   endproperty
   a_xr: assert property (p_xr) else $error("xcvr reset short");
   property p_int;
      $rose(wakeInterrupt) |-> $past(lanWakeEvent || energyEvent || busWr);
   endproperty
   a_int: assert property (p_int) else $error("irq no cause");
   property p_od;
      !wakeOutEn |-> !wakeOut;
   endproperty
   a_od: assert property (p_od) else $error("pin level undriven");
endmodule
bind pmwc_power_mgmt_wake_control pmwc_assertions pmwc_assertions_i (.*);
`default_nettype wire

/* File: dv/pmwc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmwc_host_model (
   // Clock
   input wire logic clk,
   // Register bus
   output logic busSel,
   output logic busRd,
   output logic busWr,
   output logic [7:0] busAddr,
   output logic [31:0] busWdata,
   input wire logic [31:0] busRdata,
   input wire logic busRvalid
);
   logic [31:0] rdat;
   initial {busSel, busRd, busWr, busAddr, busWdata} = '0;
   // Callers read after each wake and never send state 11
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(negedge clk);
      {busSel, busRd, busWr, busAddr, busWdata} = {1'b1, ~w, w, a, d};
      @(negedge clk);
      // Read answer stands only in the cycle after the strobe
      if (!w) rdat = busRvalid ? busRdata : 'x;
      {busSel, busRd, busWr, busAddr, busWdata} = {3'b000, ~a, ~d};
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int XR = 20;
   localparam int PU = 50;
   logic clk, nrst, busSel, busRd, busWr, busRvalid, deviceReady;
   logic lanWakeEvent, energyEvent, wakeInterrupt;
   logic xcvrResetN, wakeOut, wakeOutEn;
   logic [7:0] busAddr;
   logic [31:0] busWdata, busRdata;
   logic [1:0] powerState;
   int fail_count, checked, st;
   pmwc_power_mgmt_wake_control #(.XRST_CYC(XR), .PULSE_CYC(PU),
      .READY_CYC(4)) pmwc_power_mgmt_wake_control_i (.*);
   pmwc_host_model pmwc_host_model_i (.*);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      pmwc_host_model_i.xfer(1, a, d);
   endtask
   task automatic rk(input string n, input logic [31:0] m, e);
      pmwc_host_model_i.xfer(0, 8'h84, 0);
      chk(n, pmwc_host_model_i.rdat & m, e);
   endtask
   task automatic up;
      for (int i = 0; i < 40 && deviceReady !== 1'b1; i++) @(negedge clk);
      chk("ready", deviceReady, 1);
   endtask
   task automatic ev(input logic l);
      @(negedge clk);
      {lanWakeEvent, energyEvent} = {l, !l};
      @(negedge clk);
      {lanWakeEvent, energyEvent} = 2'b00;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      wrap_up();
   end
   initial begin
      {nrst, lanWakeEvent, energyEvent} = 3'b000;
      repeat (12) @(negedge clk);
      nrst = 1;
      up();
      wr(8'h84, 32'h0000_0302);
      rk("early write", 32'h0000_0302, 0);
      wr(8'h84, 32'h0000_0400);
      @(negedge clk);
      chk("xcvr low", xcvrResetN, 0);
      wr(8'h84, 32'h0000_0000);
      rk("xcvr bit", 32'h0000_0400, 32'h0000_0400);
      repeat (XR) @(negedge clk);
      chk("xcvr high", xcvrResetN, 1);
      rk("xcvr clear", 32'h0000_0400, 0);
      wr(8'h84, 32'h0000_034E);
      ev(0);
      chk("irq energy", wakeInterrupt, 1);
      chk("pin high", {wakeOut, wakeOutEn}, 2'b11);
      rk("cause nrg", 32'h0000_0030, 32'h0000_0010);
      repeat (PU) @(negedge clk);
      chk("pulse end", wakeOut, 0);
      wr(8'h84, 32'h0000_034A);
      chk("pol low idle", wakeOut, 1);
      wr(8'h84, 32'h0000_035E);
      chk("irq clr", wakeInterrupt, 0);
      ev(1);
      chk("irq lan", {wakeInterrupt, wakeOut}, 2'b11);
      ev(0);
      wr(8'h84, 32'h0000_0306);
      rk("cause both", 32'h0000_0030, 32'h0000_0030);
      repeat (PU) @(negedge clk);
      chk("open drain", {wakeOut, wakeOutEn}, 2'b01);
      wr(8'h84, 32'h0000_0304);
      chk("pin off", {wakeOutEn, wakeInterrupt}, 2'b01);
      for (int k = 1; k < 4; k++) begin
         st = k == 3 ? 1 : k;
         wr(8'h84, 32'h0000_0300 | (st << 12));
         @(negedge clk);
         chk("state", {powerState, deviceReady}, st << 1);
         rk("readable", 32'h0000_3000, st << 12);
         if (k == 3) wr(8'h64, 32'h0000_0000);
         else ev(k == 1);
         chk("woke", powerState, 0);
         up();
         rk("normal", 32'h0000_3001, 32'h0000_0001);
      end
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: inc/pmwc_consts.vh */
`ifndef PMWC_CONSTS_VH
`define PMWC_CONSTS_VH

// Register byte addresses
`define PMWC_ADDR_W 8
`define PMWC_OFS_POWER_CONTROL 8'h84
`define PMWC_OFS_BYTE_TEST 8'h64

// Field positions in power_control
`define PMWC_POS_STATE_HI 13
`define PMWC_POS_STATE_LO 12
`define PMWC_POS_XRST 10
`define PMWC_POS_LAN_EN 9
`define PMWC_POS_ENERGY_EN 8
`define PMWC_POS_DRV_TYPE 6
`define PMWC_POS_CAUSE_HI 5
`define PMWC_POS_CAUSE_LO 4
`define PMWC_POS_PULSE_SEL 3
`define PMWC_POS_POLARITY 2
`define PMWC_POS_PIN_EN 1
`define PMWC_POS_READY 0

// Power state codes
`define PMWC_FULL_POWER_STATE 2'h0
`define PMWC_FRAME_WAKE_STATE 2'h1
`define PMWC_ENERGY_DETECT_STATE 2'h2

// Wake cause bits
`define PMWC_CAUSE_ENERGY 0
`define PMWC_CAUSE_FRAME 1

// Timing
`define PMWC_CLK_MHZ 100
`define PMWC_XRST_US 100
`define PMWC_PULSE_MS 50
`define PMWC_READY_CYC 16

`endif

/* File: verilog/pmwc_power_mgmt_wake_control.v */
`timescale 1ns/10ps
`default_nettype none
`include "pmwc_consts.vh"

// Contract
// [R01] Power state: 0 normal, 01 frame, 10 energy
// [R02] Host never writes reserved state 11b
// [R03] Byte-test write wakes from reduced power
// [R04] Host writes only wake trigger while unready
// [R05] Writes ignored until first read after wake
// [R06] Power control readable in reduced power
// [R07] Transceiver reset held at least 100 us
// [R08] Reset bit self-clears; writes ignored while high
// [R09] LAN wake event drives enabled pin
// [R10] LAN wake event raises wake interrupt
// [R11] Energy event drives enabled pin
// [R12] Energy event raises wake interrupt
// [R13] Driver type: 0 open-drain, 1 push-pull
// [R14] Open-drain ignores polarity, active low
// [R15] Wake cause: energy, frame, both encodings
// [R16] Wake cause bits cleared by writing one
// [R17] Wake-up returns power state to normal
// [R18] Pulse select: 50 ms pulse, else level
// [R19] Push-pull polarity: set high, clear low
// [R20] Pin enable gates pin, not interrupt
// [R21] Ready bit marks device stable
module pmwc_power_mgmt_wake_control #(
   parameter XRST_CYC = `PMWC_XRST_US * `PMWC_CLK_MHZ,
   parameter PULSE_CYC = `PMWC_PULSE_MS * 1000 * `PMWC_CLK_MHZ,
   parameter READY_CYC = `PMWC_READY_CYC
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Host register bus, one-cycle strobes on clk
   input wire busSel,
   input wire busRd,
   input wire busWr,
   input wire [`PMWC_ADDR_W-1:0] busAddr,
   input wire [31:0] busWdata,
   output reg [31:0] busRdata,
   output reg busRvalid,
   // Wake events from receive and energy detectors
   input wire lanWakeEvent,
   input wire energyEvent,
   // Status toward the rest of the device
   output wire [1:0] powerState,
   output wire deviceReady,
   output wire wakeInterrupt,
   // Transceiver reset, active low
   output wire xcvrResetN,
   // Wake event output pin
   output wire wakeOut,
   output wire wakeOutEn
);

   localparam CW = 32;

   reg [1:0] stateQ;
   reg lanEnQ, energyEnQ, drvTypeQ, pulseSelQ, polQ, pinEnQ;
   reg [1:0] causeQ;
   reg readyQ, readSeenQ;
   reg [CW-1:0] readyCntQ;
   reg xrstQ;
   reg [CW-1:0] xrstCntQ;
   reg [CW-1:0] pulseCntQ;

   wire rdReq = busSel & busRd;
   wire wrReq = busSel & busWr;
   wire hitCtrl = (busAddr == `PMWC_OFS_POWER_CONTROL);
   wire hitByteTest = (busAddr == `PMWC_OFS_BYTE_TEST);
   // Control writes act only once stable and read at least once
   wire wrOk = wrReq & readyQ & readSeenQ; // [R05] [R21]
   wire ctrlWr = wrOk & hitCtrl;
   wire enterReduced = ctrlWr &
      (busWdata[`PMWC_POS_STATE_HI:`PMWC_POS_STATE_LO] !=
       `PMWC_FULL_POWER_STATE);
   wire reduced = (stateQ != `PMWC_FULL_POWER_STATE);

   // Wake events seen while the matching enable is set
   wire energyHit = energyEvent & energyEnQ; // [R11] [R12]
   wire lanHit = lanWakeEvent & lanEnQ; // [R09] [R10]
   wire wakeByEvent = (stateQ == `PMWC_FRAME_WAKE_STATE & lanHit) |
      (stateQ == `PMWC_ENERGY_DETECT_STATE & energyHit); // [R01]
   wire wakeNow = reduced & ((wrReq & hitByteTest) | wakeByEvent); // [R03]

   // Wake indication lasts while an enabled cause is pending
   wire wakeActive = (causeQ[`PMWC_CAUSE_ENERGY] & energyEnQ) |
      (causeQ[`PMWC_CAUSE_FRAME] & lanEnQ);

   function [31:0] ctrlImage;
      input dummy;
      begin
         ctrlImage = 32'h0000_0000;
         ctrlImage[`PMWC_POS_STATE_HI:`PMWC_POS_STATE_LO] = stateQ;
         ctrlImage[`PMWC_POS_XRST] = xrstQ;
         ctrlImage[`PMWC_POS_LAN_EN] = lanEnQ;
         ctrlImage[`PMWC_POS_ENERGY_EN] = energyEnQ;
         ctrlImage[`PMWC_POS_DRV_TYPE] = drvTypeQ;
         ctrlImage[`PMWC_POS_CAUSE_HI:`PMWC_POS_CAUSE_LO] = causeQ;
         ctrlImage[`PMWC_POS_PULSE_SEL] = pulseSelQ;
         ctrlImage[`PMWC_POS_POLARITY] = polQ;
         ctrlImage[`PMWC_POS_PIN_EN] = pinEnQ;
         ctrlImage[`PMWC_POS_READY] = readyQ;
      end
   endfunction

   // Read path; control register answers in every power state
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busRdata <= 32'h0000_0000;
         busRvalid <= 1'b0;
      end else begin
         busRvalid <= rdReq;
         if (rdReq) begin
            if (hitCtrl) begin
               busRdata <= ctrlImage(1'b0); // [R06]
            end else begin
               busRdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Power state, ready and first-read tracking
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stateQ <= `PMWC_FULL_POWER_STATE;
         readyQ <= 1'b0;
         readyCntQ <= {CW{1'b0}};
         readSeenQ <= 1'b0;
      end else begin
         if (wakeNow) begin
            stateQ <= `PMWC_FULL_POWER_STATE; // [R17]
            readyQ <= 1'b0;
            readyCntQ <= {CW{1'b0}};
            readSeenQ <= 1'b0; // [R05]
         end else begin
            if (ctrlWr) begin
               stateQ <=
                  busWdata[`PMWC_POS_STATE_HI:`PMWC_POS_STATE_LO]; // [R01]
               if (busWdata[`PMWC_POS_STATE_HI:`PMWC_POS_STATE_LO] !=
                   `PMWC_FULL_POWER_STATE) begin
                  readyQ <= 1'b0;
                  readSeenQ <= 1'b0;
               end
            end else if (!readyQ && !reduced) begin
               // Settle after reset or wake, then report stable
               if (readyCntQ == READY_CYC - 1) begin
                  readyQ <= 1'b1; // [R21]
               end else begin
                  readyCntQ <= readyCntQ + 1'b1;
               end
            end
            if (rdReq && !enterReduced) begin
               readSeenQ <= 1'b1; // [R05]
            end
         end
      end
   end

   // Configuration bits and wake cause
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lanEnQ <= 1'b0;
         energyEnQ <= 1'b0;
         drvTypeQ <= 1'b0;
         pulseSelQ <= 1'b0;
         polQ <= 1'b0;
         pinEnQ <= 1'b0;
         causeQ <= 2'h0;
      end else begin
         if (ctrlWr) begin
            lanEnQ <= busWdata[`PMWC_POS_LAN_EN];
            energyEnQ <= busWdata[`PMWC_POS_ENERGY_EN];
            drvTypeQ <= busWdata[`PMWC_POS_DRV_TYPE];
            pulseSelQ <= busWdata[`PMWC_POS_PULSE_SEL];
            polQ <= busWdata[`PMWC_POS_POLARITY];
            pinEnQ <= busWdata[`PMWC_POS_PIN_EN];
         end
         // Write-one clears; a same-cycle event wins
         causeQ[`PMWC_CAUSE_ENERGY] <= energyHit |
            (causeQ[`PMWC_CAUSE_ENERGY] &
             ~(ctrlWr & busWdata[`PMWC_POS_CAUSE_LO])); // [R15] [R16]
         causeQ[`PMWC_CAUSE_FRAME] <= lanHit |
            (causeQ[`PMWC_CAUSE_FRAME] &
             ~(ctrlWr & busWdata[`PMWC_POS_CAUSE_HI])); // [R15] [R16]
      end
   end

   // Transceiver reset timer
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xrstQ <= 1'b0;
         xrstCntQ <= {CW{1'b0}};
      end else if (xrstQ) begin
         if (xrstCntQ == XRST_CYC - 1) begin
            xrstQ <= 1'b0; // [R08]
         end else begin
            xrstCntQ <= xrstCntQ + 1'b1; // [R07]
         end
      end else if (ctrlWr && busWdata[`PMWC_POS_XRST]) begin
         xrstQ <= 1'b1; // [R07] [R08]
         xrstCntQ <= {CW{1'b0}};
      end
   end

   assign xcvrResetN = ~xrstQ;

   // Pulse timer restarts on each new enabled event
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulseCntQ <= {CW{1'b0}};
      end else if (energyHit || lanHit) begin
         pulseCntQ <= PULSE_CYC; // [R18]
      end else if (pulseCntQ != {CW{1'b0}}) begin
         pulseCntQ <= pulseCntQ - 1'b1;
      end
   end

   // Asserted level of the pin before driver shaping
   wire pinAssert = pinEnQ & wakeActive &
      (pulseSelQ ? (pulseCntQ != {CW{1'b0}}) : 1'b1); // [R18] [R20]

   // Open-drain pulls low only; push-pull follows polarity
   assign wakeOut = drvTypeQ ? (polQ ? pinAssert : ~pinAssert)
      : 1'b0; // [R13] [R14] [R19]
   assign wakeOutEn = drvTypeQ ? 1'b1 : pinAssert; // [R13]

   assign wakeInterrupt = wakeActive; // [R10] [R12] [R20]
   assign powerState = stateQ;
   assign deviceReady = readyQ;

endmodule
`default_nettype wire
